// [core/psub_defines.svh]
`ifndef PSUB_DEFINES_SVH
`define PSUB_DEFINES_SVH

// Register port geometry
`define PSUB_ADDR_W               5
`define PSUB_DATA_W               8

// Register addresses
`define PSUB_ADDR_TYPE_B_OPTS     5'h02
`define PSUB_ADDR_TYPE_A_OPTS     5'h03
`define PSUB_ADDR_TMR_HIGH        5'h04
`define PSUB_ADDR_TMR_LOW         5'h05

// Reset values
`define PSUB_RST_TYPE_B_OPTS      8'h00
`define PSUB_RST_TYPE_A_OPTS      8'h00
`define PSUB_RST_TMR_HIGH         8'hc2
`define PSUB_RST_TMR_LOW          8'h00

// Writable bit masks, unused bits read as zero
`define PSUB_MASK_TYPE_B_OPTS     8'hfe
`define PSUB_MASK_TYPE_A_OPTS     8'hf8
`define PSUB_MASK_TMR_HIGH        8'hff
`define PSUB_MASK_TMR_LOW         8'hff

// Type B framing fields
`define PSUB_GUARD_CODE_HI        7
`define PSUB_GUARD_CODE_LO        5
`define PSUB_FRAME_END_LOW_SEL    4
`define PSUB_FRAME_START_HIGH_SEL 3
`define PSUB_FRAME_START_LOW_SEL  2
`define PSUB_GUARD_AFTER_LAST     1

// Type A rate and parity fields
`define PSUB_SEP_RATE_EN          7
`define PSUB_RATE_SEL_HI          6
`define PSUB_RATE_SEL_LO          5
`define PSUB_ALT_PARITY_TX        4
`define PSUB_ALT_PARITY_RX        3

// Delay timer fields
`define PSUB_START_SEL_HI         7
`define PSUB_START_SEL_LO         6
`define PSUB_COUNT_TOP_HI         5
`define PSUB_COUNT_TOP_LO         0
`define PSUB_COUNT_W              14
`define PSUB_COUNT_ZERO           14'h0000

// Frame phase lengths in elementary time units
`define PSUB_ETU_END_LOW_LONG     4'hb
`define PSUB_ETU_END_LOW_SHORT    4'ha
`define PSUB_ETU_START_HIGH_LONG  2'h3
`define PSUB_ETU_START_HIGH_SHORT 2'h2
`define PSUB_ETU_START_LOW_LONG   4'hb
`define PSUB_ETU_START_LOW_SHORT  4'ha

// Timing: system clock rate and delay step
`define PSUB_CLK_MHZ              25
`define PSUB_CLK_NS               (1000 / `PSUB_CLK_MHZ)
`define PSUB_DLY_TICK_NS          590

`endif

// [core/psub_pkg.sv]
package psub_pkg;

    // Transmit bit rate codes
    typedef enum logic [1:0] {
        PSUB_RATE_106 = 2'h0,
        PSUB_RATE_212 = 2'h1,
        PSUB_RATE_424 = 2'h2,
        PSUB_RATE_848 = 2'h3
    } psub_rate_t;

    // Delay timer start event codes
    typedef enum logic [1:0] {
        PSUB_START_TX_BEGIN = 2'h0,
        PSUB_START_TX_END   = 2'h1,
        PSUB_START_RX_BEGIN = 2'h2,
        PSUB_START_RX_END   = 2'h3
    } psub_start_t;

    // Delay timer states
    typedef enum logic [1:0] {
        PSUB_TMR_IDLE = 2'b01,
        PSUB_TMR_RUN  = 2'b10
    } psub_tmr_state_t;

    // Frame start markers from the framers, one-cycle pulses
    typedef struct packed {
        logic tx_start_begin;
        logic tx_start_end;
        logic rx_start_begin;
        logic rx_start_end;
    } psub_frame_evt_t;

    // Decoded settings for the encoders, decoders and framer
    typedef struct packed {
        logic [2:0]  guard_time_code;
        logic        guard_after_last;
        logic [3:0]  frame_end_low_etu;
        logic [1:0]  frame_start_high_etu;
        logic [3:0]  frame_start_low_etu;
        psub_rate_t  tx_rate;
        logic        alt_parity_transmit;
        logic        alt_parity_receive;
        psub_start_t delay_start_sel;
        logic [13:0] delay_count;
        logic        delay_enabled;
    } psub_cfg_t;

endpackage

// [core/psub_delay_timer.sv]
`timescale 1ns/1ns
`include "psub_defines.svh"

module psub_delay_timer
    import psub_pkg::*;
#(
    parameter logic [15:0] TICK_NS = 16'(`PSUB_DLY_TICK_NS)
) (
    // Clock and reset
    input  logic            clk_sys,
    input  logic            rst,
    // Settings
    input  logic            clear,
    input  psub_start_t     start_sel,
    input  logic [13:0]     length,
    // Start events
    input  psub_frame_evt_t events,
    // Results
    output logic            tx_start,
    output logic            busy
);

    localparam logic [15:0] CLK_NS = 16'(`PSUB_CLK_NS);

    psub_tmr_state_t state_reg;
    psub_tmr_state_t state_next;
    logic [13:0]     cnt_reg;
    logic [13:0]     cnt_next;
    logic [15:0]     acc_reg;
    logic [15:0]     acc_next;
    logic            pulse_reg;
    logic            pulse_next;
    logic            start_evt;

    // Pick the event chosen by the start selector
    always_comb begin
        case (start_sel)
            PSUB_START_TX_BEGIN: start_evt = events.tx_start_begin;
            PSUB_START_TX_END:   start_evt = events.tx_start_end;
            PSUB_START_RX_BEGIN: start_evt = events.rx_start_begin;
            PSUB_START_RX_END:   start_evt = events.rx_start_end;
            default:             start_evt = 1'b0;
        endcase
    end

    // Tick accumulator yields one step per tick period on average
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        acc_next   = acc_reg;
        pulse_next = 1'b0;
        case (state_reg)
            PSUB_TMR_IDLE: begin
                if (start_evt) begin
                    if (length == `PSUB_COUNT_ZERO) begin
                        pulse_next = 1'b1;
                    end else begin
                        state_next = PSUB_TMR_RUN;
                        cnt_next   = `PSUB_COUNT_ZERO;
                        acc_next   = 16'h0000;
                    end
                end
            end
            PSUB_TMR_RUN: begin
                if (acc_reg + CLK_NS >= TICK_NS) begin
                    acc_next = acc_reg + CLK_NS - TICK_NS;
                    if (cnt_reg + 14'h0001 >= length) begin
                        pulse_next = 1'b1;
                        state_next = PSUB_TMR_IDLE;
                        cnt_next   = `PSUB_COUNT_ZERO;
                    end else begin
                        cnt_next = cnt_reg + 14'h0001;
                    end
                end else begin
                    acc_next = acc_reg + CLK_NS;
                end
            end
            default: begin
                state_next = PSUB_TMR_IDLE;
            end
        endcase
        if (clear) begin
            state_next = PSUB_TMR_IDLE;
            cnt_next   = `PSUB_COUNT_ZERO;
            acc_next   = 16'h0000;
            pulse_next = 1'b0;
        end
    end

    // State registers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_reg <= PSUB_TMR_IDLE;
            cnt_reg   <= `PSUB_COUNT_ZERO;
            acc_reg   <= 16'h0000;
            pulse_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            acc_reg   <= acc_next;
            pulse_reg <= pulse_next;
        end
    end

    assign tx_start = pulse_reg;
    assign busy     = (state_reg == PSUB_TMR_RUN);

endmodule

// [core/psub_options.sv]
`timescale 1ns/1ns
`include "psub_defines.svh"

module psub_options
    import psub_pkg::*;
#(
    parameter logic [15:0] TICK_NS = 16'(`PSUB_DLY_TICK_NS)
) (
    // Clock and reset
    input  logic                    clk_sys,
    input  logic                    rst,
    // Enable pin, low holds settings at defaults
    input  logic                    en_pin,
    // Register port from the host interface logic
    input  logic [`PSUB_ADDR_W-1:0] reg_addr,
    input  logic [`PSUB_DATA_W-1:0] reg_wdata,
    input  logic                    reg_wr,
    input  logic                    reg_rd,
    output logic [`PSUB_DATA_W-1:0] reg_rdata,
    output logic                    reg_rvalid,
    // Protocol select write strobe and selection state
    input  logic                    proto_sel_wr,
    input  logic                    proto_high_rate_ab,
    input  psub_rate_t              rx_rate,
    // Settings to the framers and coders
    output psub_cfg_t               cfg,
    // Delayed transmission
    input  psub_frame_evt_t         frame_events,
    output logic                    delayed_tx_start,
    output logic                    delay_busy,
    // Type A high-rate transmit parity
    input  logic                    tx_par_req,
    input  logic [7:0]              tx_par_byte,
    input  logic                    tx_par_last,
    output logic                    tx_par_bit,
    output logic                    tx_par_valid,
    // Type A high-rate receive parity check
    input  logic                    rx_par_req,
    input  logic [7:0]              rx_par_byte,
    input  logic                    rx_par_rcvd,
    input  logic                    rx_par_last,
    output logic                    rx_par_err,
    output logic                    rx_par_valid
);

    // Expected parity: odd, except even on the last byte in alternate mode
    function automatic logic parity_of(input logic [7:0] data, input logic last,
                                       input logic alt);
        logic odd_bit;
        odd_bit = ~(^data);
        if (alt && last) begin
            parity_of = ~odd_bit;
        end else begin
            parity_of = odd_bit;
        end
    endfunction

    // Store a write through the writable bit mask
    function automatic logic [7:0] masked(input logic [7:0] data, input logic [7:0] mask);
        masked = data & mask;
    endfunction

    // Enable synchroniser
    logic            en_meta_reg;
    logic            en_sync_reg;

    // Settings registers
    logic [7:0]      type_b_tx_framing_options_reg;
    logic [7:0]      type_b_tx_framing_options_next;
    logic [7:0]      type_a_rate_parity_options_reg;
    logic [7:0]      type_a_rate_parity_options_next;
    logic [7:0]      delay_timer_high_control_reg;
    logic [7:0]      delay_timer_high_control_next;
    logic [7:0]      delay_timer_low_length_reg;
    logic [7:0]      delay_timer_low_length_next;

    // Read port
    logic [7:0]      rdata_reg;
    logic [7:0]      rdata_next;
    logic            rvalid_reg;
    logic            rvalid_next;

    // Decoded settings, parity
    psub_cfg_t       cfg_reg;
    psub_cfg_t       cfg_next;
    logic            tx_bit_reg;
    logic            tx_bit_next;
    logic            tx_valid_reg;
    logic            tx_valid_next;
    logic            rx_err_reg;
    logic            rx_err_next;
    logic            rx_valid_reg;
    logic            rx_valid_next;

    // Reload and delay length
    logic            defaults_all;
    logic            defaults_proto;
    logic [13:0]     delay_length;
    logic            timer_clear;

    // Enable pin synchroniser, first stage feeds only the second
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            en_meta_reg <= 1'b0;
            en_sync_reg <= 1'b0;
        end else begin
            en_meta_reg <= en_pin;
            en_sync_reg <= en_meta_reg;
        end
    end

    assign defaults_all   = ~en_sync_reg;
    assign defaults_proto = defaults_all | proto_sel_wr;

    // Register writes; default reload wins over a host write
    always_comb begin
        type_b_tx_framing_options_next  = type_b_tx_framing_options_reg;
        type_a_rate_parity_options_next = type_a_rate_parity_options_reg;
        delay_timer_high_control_next   = delay_timer_high_control_reg;
        delay_timer_low_length_next     = delay_timer_low_length_reg;
        if (reg_wr) begin
            case (reg_addr)
                `PSUB_ADDR_TYPE_B_OPTS: begin
                    type_b_tx_framing_options_next =
                        masked(reg_wdata, `PSUB_MASK_TYPE_B_OPTS);
                end
                `PSUB_ADDR_TYPE_A_OPTS: begin
                    type_a_rate_parity_options_next =
                        masked(reg_wdata, `PSUB_MASK_TYPE_A_OPTS);
                end
                `PSUB_ADDR_TMR_HIGH: begin
                    delay_timer_high_control_next =
                        masked(reg_wdata, `PSUB_MASK_TMR_HIGH);
                end
                `PSUB_ADDR_TMR_LOW: begin
                    delay_timer_low_length_next =
                        masked(reg_wdata, `PSUB_MASK_TMR_LOW);
                end
                default: begin
                end
            endcase
        end
        if (defaults_all) begin
            type_b_tx_framing_options_next = `PSUB_RST_TYPE_B_OPTS;
        end
        if (defaults_proto) begin
            type_a_rate_parity_options_next = `PSUB_RST_TYPE_A_OPTS;
            delay_timer_high_control_next   = `PSUB_RST_TMR_HIGH;
            delay_timer_low_length_next     = `PSUB_RST_TMR_LOW;
        end
    end

    // Settings registers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            type_b_tx_framing_options_reg  <= `PSUB_RST_TYPE_B_OPTS;
            type_a_rate_parity_options_reg <= `PSUB_RST_TYPE_A_OPTS;
            delay_timer_high_control_reg   <= `PSUB_RST_TMR_HIGH;
            delay_timer_low_length_reg     <= `PSUB_RST_TMR_LOW;
        end else begin
            type_b_tx_framing_options_reg  <= type_b_tx_framing_options_next;
            type_a_rate_parity_options_reg <= type_a_rate_parity_options_next;
            delay_timer_high_control_reg   <= delay_timer_high_control_next;
            delay_timer_low_length_reg     <= delay_timer_low_length_next;
        end
    end

    // Read back, answered one cycle after the strobe
    always_comb begin
        rdata_next  = rdata_reg;
        rvalid_next = reg_rd;
        if (reg_rd) begin
            case (reg_addr)
                `PSUB_ADDR_TYPE_B_OPTS: rdata_next = type_b_tx_framing_options_reg;
                `PSUB_ADDR_TYPE_A_OPTS: rdata_next = type_a_rate_parity_options_reg;
                `PSUB_ADDR_TMR_HIGH:    rdata_next = delay_timer_high_control_reg;
                `PSUB_ADDR_TMR_LOW:     rdata_next = delay_timer_low_length_reg;
                default:                rdata_next = 8'h00;
            endcase
        end
    end

    // Read data registers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rdata_reg  <= 8'h00;
            rvalid_reg <= 1'b0;
        end else begin
            rdata_reg  <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    // Delay length, upper six bits from the high register
    assign delay_length = {delay_timer_high_control_reg[`PSUB_COUNT_TOP_HI:`PSUB_COUNT_TOP_LO],
                           delay_timer_low_length_reg};

    // Decode the settings for the consumers
    always_comb begin
        cfg_next.guard_time_code =
            type_b_tx_framing_options_reg[`PSUB_GUARD_CODE_HI:`PSUB_GUARD_CODE_LO];
        cfg_next.guard_after_last =
            type_b_tx_framing_options_reg[`PSUB_GUARD_AFTER_LAST];
        cfg_next.frame_end_low_etu =
            type_b_tx_framing_options_reg[`PSUB_FRAME_END_LOW_SEL] ?
            `PSUB_ETU_END_LOW_LONG : `PSUB_ETU_END_LOW_SHORT;
        cfg_next.frame_start_high_etu =
            type_b_tx_framing_options_reg[`PSUB_FRAME_START_HIGH_SEL] ?
            `PSUB_ETU_START_HIGH_LONG : `PSUB_ETU_START_HIGH_SHORT;
        cfg_next.frame_start_low_etu =
            type_b_tx_framing_options_reg[`PSUB_FRAME_START_LOW_SEL] ?
            `PSUB_ETU_START_LOW_LONG : `PSUB_ETU_START_LOW_SHORT;
        if (type_a_rate_parity_options_reg[`PSUB_SEP_RATE_EN] && proto_high_rate_ab) begin
            cfg_next.tx_rate = psub_rate_t'(type_a_rate_parity_options_reg[
                `PSUB_RATE_SEL_HI:`PSUB_RATE_SEL_LO]);
        end else begin
            cfg_next.tx_rate = rx_rate;
        end
        cfg_next.alt_parity_transmit =
            type_a_rate_parity_options_reg[`PSUB_ALT_PARITY_TX];
        cfg_next.alt_parity_receive =
            type_a_rate_parity_options_reg[`PSUB_ALT_PARITY_RX];
        cfg_next.delay_start_sel = psub_start_t'(delay_timer_high_control_reg[
            `PSUB_START_SEL_HI:`PSUB_START_SEL_LO]);
        cfg_next.delay_count   = delay_length;
        cfg_next.delay_enabled = (delay_length != `PSUB_COUNT_ZERO);
    end

    // Parity generation and checking
    always_comb begin
        tx_valid_next = tx_par_req;
        tx_bit_next   = tx_bit_reg;
        rx_valid_next = rx_par_req;
        rx_err_next   = 1'b0;
        if (tx_par_req) begin
            tx_bit_next = parity_of(tx_par_byte, tx_par_last,
                                    cfg_reg.alt_parity_transmit);
        end
        if (rx_par_req) begin
            rx_err_next = rx_par_rcvd != parity_of(rx_par_byte, rx_par_last,
                                                   cfg_reg.alt_parity_receive);
        end
    end

    // Decoded settings and parity registers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cfg_reg      <= '0;
            tx_bit_reg   <= 1'b0;
            tx_valid_reg <= 1'b0;
            rx_err_reg   <= 1'b0;
            rx_valid_reg <= 1'b0;
        end else begin
            cfg_reg      <= cfg_next;
            tx_bit_reg   <= tx_bit_next;
            tx_valid_reg <= tx_valid_next;
            rx_err_reg   <= rx_err_next;
            rx_valid_reg <= rx_valid_next;
        end
    end

    // A running delay is abandoned when its settings are reloaded
    assign timer_clear = defaults_proto;

    // Delayed transmission timer
    psub_delay_timer #(
        .TICK_NS   (TICK_NS)
    ) u_delay_timer (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .clear     (timer_clear),
        .start_sel (cfg_reg.delay_start_sel),
        .length    (cfg_reg.delay_count),
        .events    (frame_events),
        .tx_start  (delayed_tx_start),
        .busy      (delay_busy)
    );

    // Outputs
    assign reg_rdata    = rdata_reg;
    assign reg_rvalid   = rvalid_reg;
    assign cfg          = cfg_reg;
    assign tx_par_bit   = tx_bit_reg;
    assign tx_par_valid = tx_valid_reg;
    assign rx_par_err   = rx_err_reg;
    assign rx_par_valid = rx_valid_reg;

endmodule

// [verification/psub_options_checker.sv]
`timescale 1ns/1ns
module psub_options_checker
    import psub_pkg::*;
(
    // Clock and reset
    input logic            clk_sys,
    input logic            rst,
    // Register side
    input logic            en_pin,
    input logic [4:0]      reg_addr,
    input logic [7:0]      reg_wdata,
    input logic            reg_wr,
    input logic            reg_rd,
    input logic            reg_rvalid,
    input logic            proto_sel_wr,
    input psub_cfg_t       cfg,
    // Timer and parity
    input psub_frame_evt_t frame_events,
    input logic            delayed_tx_start,
    input logic            delay_busy,
    input logic            tx_par_req,
    input logic [7:0]      tx_par_byte,
    input logic            tx_par_last,
    input logic            tx_par_bit,
    input logic            tx_par_valid,
    input logic            rx_par_req,
    input logic [7:0]      rx_par_byte,
    input logic            rx_par_rcvd,
    input logic            rx_par_last,
    input logic            rx_par_err,
    input logic            rx_par_valid
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    // Write to the framing register with the enable settled
    sequence wr_b;
        (en_pin && !rst)[*4] ##0 (reg_wr && reg_addr == 5'h02);
    endsequence

    AST_GUARD: assert property (wr_b |-> ##2
        cfg.guard_time_code == $past(reg_wdata[7:5], 2)) else $error("guard code wrong");
    AST_FRAME: assert property (wr_b |-> ##2
        cfg.frame_end_low_etu == ($past(reg_wdata[4], 2) ? 4'hb : 4'ha)
        && cfg.frame_start_high_etu == ($past(reg_wdata[3], 2) ? 2'h3 : 2'h2)
        && cfg.frame_start_low_etu == ($past(reg_wdata[2], 2) ? 4'hb : 4'ha))
        else $error("frame lengths wrong");
    AST_LAST: assert property (wr_b |-> ##2
        cfg.guard_after_last == $past(reg_wdata[1], 2)) else $error("last guard wrong");
    AST_RVALID: assert property (reg_rd |=> reg_rvalid) else $error("no read answer");
    AST_RELOAD: assert property (proto_sel_wr |=> ##1
        cfg.delay_count == 14'h0200 && cfg.delay_start_sel == PSUB_START_RX_END
        && !cfg.alt_parity_transmit && !cfg.alt_parity_receive) else $error("no reload");
    AST_ZERO: assert property (
        !cfg.delay_enabled |=> !$rose(delay_busy)) else $error("timer ran at zero length");
    AST_ONE: assert property (
        delayed_tx_start |=> !delayed_tx_start) else $error("start pulse too long");
    AST_NODELAY: assert property ((en_pin && !rst)[*4] ##0
        (frame_events.tx_start_begin && !delay_busy && !delayed_tx_start && !proto_sel_wr
        && cfg.delay_count == 14'h0000 && cfg.delay_start_sel == PSUB_START_TX_BEGIN)
        |=> delayed_tx_start) else $error("zero length not immediate");
    AST_TXPAR: assert property (tx_par_req |=> tx_par_valid && tx_par_bit ==
        ($past(cfg.alt_parity_transmit && tx_par_last) ? ^$past(tx_par_byte)
        : ~^$past(tx_par_byte))) else $error("tx parity wrong");
    AST_RXPAR: assert property (rx_par_req |=> rx_par_valid && rx_par_err ==
        ($past(rx_par_rcvd) != ($past(cfg.alt_parity_receive && rx_par_last)
        ? ^$past(rx_par_byte) : ~^$past(rx_par_byte)))) else $error("rx parity wrong");
endmodule

bind psub_options psub_options_checker u_chk (
    .clk_sys, .rst, .en_pin, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rvalid,
    .proto_sel_wr, .cfg, .frame_events, .delayed_tx_start, .delay_busy,
    .tx_par_req, .tx_par_byte, .tx_par_last, .tx_par_bit, .tx_par_valid,
    .rx_par_req, .rx_par_byte, .rx_par_rcvd, .rx_par_last, .rx_par_err, .rx_par_valid
);

// [verification/psub_host_model.sv]
`timescale 1ns/1ns
module psub_host_model (
    // Clock
    input  logic       clk_sys,
    // Register port
    output logic [4:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic       reg_wr,
    output logic       reg_rd,
    input  logic [7:0] reg_rdata,
    input  logic       reg_rvalid
);
    // Idle bus
    initial begin
        reg_addr = 5'h1f;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // Write; rate choices go through 0x03 only
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk_sys) #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk_sys) #1;
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
    // Read; answer taken after the edge that raises valid
    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        @(posedge clk_sys) #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk_sys) #1;
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
    endtask
endmodule

// [verification/test_protocol_subset_options.sv]
`timescale 1ns/1ns
module test_protocol_subset_options
    import psub_pkg::*;
;
    localparam int TICK = 80;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic en_pin = 1'b1;
    logic proto_sel_wr = 1'b0;
    logic hr = 1'b0;
    logic tq = 1'b0, tl = 1'b0, rq = 1'b0, rl = 1'b0, rc = 1'b0;
    logic [7:0] tb_b = 8'h00, rb = 8'h00, rd_v, d;
    logic [4:0] reg_addr, a, b;
    logic [7:0] reg_wdata, reg_rdata;
    logic reg_wr, reg_rd, reg_rvalid, dts, busy, tpb, tpv, rpe, rpv;
    psub_rate_t rx_rate = PSUB_RATE_106;
    psub_frame_evt_t frame_events = '0;
    psub_cfg_t cfg;
    logic [7:0] sh [8];
    int n_fail = 0, check_count = 0, cyc = 0;

    always #20 clk_sys = ~clk_sys;

    psub_host_model u_host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
    psub_options #(.TICK_NS(16'(TICK))) u_dut (.clk_sys(clk_sys), .rst(rst), .en_pin(en_pin),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .proto_sel_wr(proto_sel_wr),
        .proto_high_rate_ab(hr), .rx_rate(rx_rate), .cfg(cfg), .frame_events(frame_events),
        .delayed_tx_start(dts), .delay_busy(busy), .tx_par_req(tq), .tx_par_byte(tb_b),
        .tx_par_last(tl), .tx_par_bit(tpb), .tx_par_valid(tpv), .rx_par_req(rq),
        .rx_par_byte(rb), .rx_par_rcvd(rc), .rx_par_last(rl), .rx_par_err(rpe),
        .rx_par_valid(rpv));

    task automatic give_verdict();
        if (n_fail == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // Default and writable mask of each address
    function automatic logic [7:0] dv(input logic [4:0] x);
        return (x == 5'h04) ? 8'hc2 : 8'h00;
    endfunction
    function automatic logic [7:0] msk(input logic [4:0] x);
        return (x == 5'h02) ? 8'hfe : (x == 5'h03) ? 8'hf8 : (x inside {4, 5}) ? 8'hff : 8'h00;
    endfunction
    function automatic logic [15:0] fb(input logic [7:0] v);
        return {2'h0, v[7:5], v[1], v[4] ? 4'hb : 4'ha, v[3] ? 2'h3 : 2'h2, v[2] ? 4'hb : 4'ha};
    endfunction
    function automatic logic par(input logic [7:0] v, input logic last, input logic alt);
        return (alt && last) ? ^v : ~^v;
    endfunction
    // Fire one frame event, optionally abort, count cycles to the start pulse
    task automatic tmr(input logic [3:0] e, input int n, input logic ab);
        int k;
        frame_events = e;
        @(posedge clk_sys) #1;
        frame_events = '0;
        proto_sel_wr = ab;
        k = 1;
        while (dts !== 1'b1 && k < 60) begin
            @(posedge clk_sys) #1;
            proto_sel_wr = 1'b0;
            k++;
        end
        chk(k, n);
    endtask

    // Cycle ceiling
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            give_verdict();
        end
    end

    initial begin
        void'($urandom(48923));
        for (int i = 0; i < 8; i++) sh[i] = dv(i[4:0]);
        wt(5);
        rst = 1'b0;
        wt(3);
        // Random writes, reads of random addresses, decoded settings
        for (int i = 0; i < 60; i++) begin
            a = 5'($urandom_range(7));
            b = 5'($urandom_range(7));
            d = 8'($urandom);
            hr = 1'($urandom);
            rx_rate = psub_rate_t'($urandom_range(3));
            u_host.wr(a, d);
            sh[a] = d & msk(a);
            u_host.rd(b, rd_v);
            chk(rd_v, sh[b]);
            chk({2'h0, cfg.guard_time_code, cfg.guard_after_last, cfg.frame_end_low_etu,
                 cfg.frame_start_high_etu, cfg.frame_start_low_etu}, fb(sh[2]));
            chk(cfg.tx_rate, (sh[3][7] && hr) ? sh[3][6:5] : rx_rate);
            chk({cfg.delay_start_sel, cfg.delay_count}, {sh[4], sh[5]});
            chk(cfg.delay_enabled, {sh[4][5:0], sh[5]} != 0);
        end
        // Reload by protocol write, then by enable low
        for (int m = 0; m < 2; m++) begin
            for (int i = 2; i < 6; i++) u_host.wr(i[4:0], 8'hff);
            proto_sel_wr = (m == 0);
            en_pin = (m == 0);
            wt(3);
            proto_sel_wr = 1'b0;
            en_pin = 1'b1;
            wt(4);
            for (int i = 2; i < 6; i++) begin
                u_host.rd(i[4:0], rd_v);
                chk(rd_v, (m == 0 && i == 2) ? 8'hfe : dv(i[4:0]));
            end
        end
        // Every start event, a stray event first, then zero length
        for (int c = 0; c < 4; c++) begin
            u_host.wr(5'h04, {2'(c), 6'h00});
            u_host.wr(5'h05, 8'h03);
            wt(2);
            frame_events = 4'h8 >> ((c + 1) % 4);
            @(posedge clk_sys) #1;
            tmr(4'h8 >> c, 3 * (TICK / 40) + 1, 1'b0);
            u_host.wr(5'h05, 8'h00);
            wt(2);
            tmr(4'h8 >> c, 1, 1'b0);
        end
        u_host.wr(5'h05, 8'h04);
        wt(2);
        tmr(4'h1, 60, 1'b1);
        // Back-to-back parity requests, plain and alternate
        for (int m = 0; m < 2; m++) begin
            u_host.wr(5'h03, {3'h0, 1'(m), 1'(m), 3'h0});
            wt(2);
            tq = 1'b1;
            rq = 1'b1;
            repeat (30) begin
                tb_b = 8'($urandom);
                rb = 8'($urandom);
                {tl, rl, rc} = 3'($urandom);
                @(posedge clk_sys) #1;
                chk({tpv, tpb}, {1'b1, par(tb_b, tl, 1'(m))});
                chk({rpv, rpe}, {1'b1, rc != par(rb, rl, 1'(m))});
            end
            tq = 1'b0;
            rq = 1'b0;
        end
        give_verdict();
    end
endmodule
